// File: common/pin_mux_pkg.sv
// Shared constants and carrier types for the port B/C pin function mux
package pin_mux_pkg;

    // Pin counts
    localparam int B_PINS = 2;
    localparam int C_PINS = 6;

    // Port B bit positions inside the block
    localparam int B6 = 0;
    localparam int B7 = 1;

    // Port C lane positions for bits 0,1,2,4,5,6
    localparam int C0 = 0;
    localparam int C1 = 1;
    localparam int C2 = 2;
    localparam int C4 = 3;
    localparam int C5 = 4;
    localparam int C6 = 5;

    // Reset values: all pins GPIO, all inputs, outputs low
    localparam logic [1:0] RST_B6_SEL  = 2'h0;
    localparam logic [1:0] RST_B7_SEL  = 2'h0;
    localparam logic [5:0] RST_C_ANA   = 6'h00;
    localparam logic [1:0] RST_C_REF   = 2'h0;
    localparam logic [7:0] RST_DIR     = 8'h00;
    localparam logic [7:0] RST_DOUT    = 8'h00;

    // Port B6 function select
    typedef enum logic [1:0] {
        B6_GPIO  = 2'b00,
        B6_RX    = 2'b01,
        B6_SDA   = 2'b10,
        B6_EXT_CLOCK_IN = 2'b11
    } b6_func_e;

    // Port B7 function select
    typedef enum logic [1:0] {
        B7_GPIO = 2'b00,
        B7_TX   = 2'b01,
        B7_SCL  = 2'b10,
        B7_RSVD = 2'b11
    } b7_func_e;

    // Control bits from the system integration unit and clock synthesis unit
    typedef struct packed {
        logic [1:0] b6_sel;
        logic [1:0] b7_sel;
        logic       i2c_on_b1_b0;
        logic [5:0] c_analog;
        logic [1:0] c_ref_high;
        logic       osc_clock_mode_bit;
    } mux_ctrl_s;

    // GPIO port controller view: direction and output value per pin
    typedef struct packed {
        logic [7:0] dir;
        logic [7:0] dout;
    } gpio_ctrl_s;

    // One pad: output, output enable
    typedef struct packed {
        logic o;
        logic oe;
    } pad_drive_s;

    // Serial and I2C peripheral side
    typedef struct packed {
        logic serial0_tx_out;
        logic serial0_tx_oe;
        logic serial0_single_wire;
        logic sda_out_oe;
        logic scl_out_oe;
    } periph_drive_s;

endpackage : pin_mux_pkg

// File: logic/pin_cell.sv
// One pad cell: picks GPIO or alternate drive and synchronises the pad input
`timescale 1ns/1ps
module pin_cell
    import pin_mux_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // Selection
    input  wire logic alt_sel,
    input  wire logic analog_sel,
    // GPIO drive
    input  wire logic gpio_dir,
    input  wire logic gpio_dout,
    // Alternate drive
    input  wire logic alt_o,
    input  wire logic alt_oe,
    // Pad
    input  wire logic pad_i,
    output logic      pad_o,
    output logic      pad_oe,
    // Synchronised pad level
    output logic      pad_sync
);

    logic meta;
    logic next_pad_o;
    logic next_pad_oe;

    // Analog use parks the digital driver so the pin floats for the converter
    always_comb begin
        if (analog_sel) begin
            next_pad_o  = 1'b0;
            next_pad_oe = 1'b0;
        end else if (alt_sel) begin
            next_pad_o  = alt_o;
            next_pad_oe = alt_oe;
        end else begin
            next_pad_o  = gpio_dout;
            next_pad_oe = gpio_dir;
        end
    end

    // Reset leaves the pad an undriven GPIO input
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pad_o    <= 1'b0;
            pad_oe   <= 1'b0;
            meta     <= 1'b0;
            pad_sync <= 1'b0;
        end else begin
            pad_o    <= next_pad_o;
            pad_oe   <= next_pad_oe;
            meta     <= pad_i;
            pad_sync <= meta;
        end
    end

endmodule : pin_cell

// File: logic/port_b_c_pin_function_mux.sv
// Pin function mux for port B bits 6,7 and port C bits 0,1,2,4,5,6
`timescale 1ns/1ps
module port_b_c_pin_function_mux
    import pin_mux_pkg::*;
(
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          reset_n,
    // Control from system integration and clock synthesis units
    input  wire mux_ctrl_s     ctrl,
    input  wire gpio_ctrl_s    gpio,
    // Peripheral drive
    input  wire periph_drive_s periph,
    // Port B pads 6,7 and port C pads
    input  wire logic [1:0]    port_b_pad_i,
    output logic      [1:0]    port_b_pad_o,
    output logic      [1:0]    port_b_pad_oe,
    input  wire logic [5:0]    port_c_pad_i,
    output logic      [5:0]    port_c_pad_o,
    output logic      [5:0]    port_c_pad_oe,
    // Synchronised GPIO input levels, B6,B7 then C lanes
    output logic      [7:0]    gpio_din,
    // Peripheral inputs
    output logic               serial0_rx_in,
    output logic               sda_in,
    output logic               scl_in,
    output logic               ext_clock_in,
    output logic               ext_clock_valid,
    // Analog routing enables
    output logic      [2:0]    conv_a_chan_en,
    output logic      [2:0]    conv_b_chan_en,
    output logic               comparator_a_in3,
    output logic               comparator_b_in3,
    output logic               conv_a_ref_high,
    output logic               conv_b_ref_high,
    // I2C moved to port B bits 1 and 0
    output logic               i2c_alt_route
);

    // Registered control so every output settles from reset as plain GPIO
    mux_ctrl_s ctl;
    mux_ctrl_s next_ctl;
    logic [1:0] b_alt;
    logic [1:0] b_alt_o;
    logic [1:0] b_alt_oe;
    logic [5:0] c_ana;
    logic [1:0] b_sync;
    logic [5:0] c_sync;
    logic       next_rx;
    logic       next_sda;
    logic       next_scl;
    logic       next_clk;
    logic       next_clk_valid;

    always_comb begin
        next_ctl = ctrl;
        if (ctrl.b6_sel == B6_EXT_CLOCK_IN && !ctrl.osc_clock_mode_bit) begin
            next_ctl.b6_sel = B6_GPIO;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctl.b6_sel             <= RST_B6_SEL;
            ctl.b7_sel             <= RST_B7_SEL;
            ctl.i2c_on_b1_b0       <= 1'b0;
            ctl.c_analog           <= RST_C_ANA;
            ctl.c_ref_high         <= RST_C_REF;
            ctl.osc_clock_mode_bit <= 1'b0;
        end else begin
            ctl <= next_ctl;
        end
    end

    // I2C on B6/B7 only while not moved to B1/B0
    always_comb begin
        b_alt[B6]    = ctl.b6_sel != B6_GPIO;
        b_alt[B7]    = ctl.b7_sel != B7_GPIO && ctl.b7_sel != B7_RSVD;
        b_alt_o      = 2'b00;
        b_alt_oe     = 2'b00;
        if (ctl.b6_sel == B6_SDA && !ctl.i2c_on_b1_b0) begin
            b_alt_oe[B6] = periph.sda_out_oe;
        end
        if (ctl.b7_sel == B7_TX) begin
            b_alt_o[B7]  = periph.serial0_tx_out;
            b_alt_oe[B7] = periph.serial0_tx_oe;
        end else if (ctl.b7_sel == B7_SCL && !ctl.i2c_on_b1_b0) begin
            b_alt_oe[B7] = periph.scl_out_oe;
        end
        c_ana = ctl.c_analog;
        c_ana[C2] = ctl.c_analog[C2] | ctl.c_ref_high[0];
        c_ana[C6] = ctl.c_analog[C6] | ctl.c_ref_high[1];
    end

    // Port B pad cells
    pin_cell u_b6 (
        .clk        (clk),
        .reset_n    (reset_n),
        .alt_sel    (b_alt[B6]),
        .analog_sel (1'b0),
        .gpio_dir   (gpio.dir[0]),
        .gpio_dout  (gpio.dout[0]),
        .alt_o      (b_alt_o[B6]),
        .alt_oe     (b_alt_oe[B6]),
        .pad_i      (port_b_pad_i[B6]),
        .pad_o      (port_b_pad_o[B6]),
        .pad_oe     (port_b_pad_oe[B6]),
        .pad_sync   (b_sync[B6])
    );

    pin_cell u_b7 (
        .clk        (clk),
        .reset_n    (reset_n),
        .alt_sel    (b_alt[B7]),
        .analog_sel (1'b0),
        .gpio_dir   (gpio.dir[1]),
        .gpio_dout  (gpio.dout[1]),
        .alt_o      (b_alt_o[B7]),
        .alt_oe     (b_alt_oe[B7]),
        .pad_i      (port_b_pad_i[B7]),
        .pad_o      (port_b_pad_o[B7]),
        .pad_oe     (port_b_pad_oe[B7]),
        .pad_sync   (b_sync[B7])
    );

    // Port C pad cells; analog select parks the digital driver
    for (genvar i = 0; i < C_PINS; i++) begin : g_c
        pin_cell u_c (
            .clk        (clk),
            .reset_n    (reset_n),
            .alt_sel    (1'b0),
            .analog_sel (c_ana[i]),
            .gpio_dir   (gpio.dir[i+2]),
            .gpio_dout  (gpio.dout[i+2]),
            .alt_o      (1'b0),
            .alt_oe     (1'b0),
            .pad_i      (port_c_pad_i[i]),
            .pad_o      (port_c_pad_o[i]),
            .pad_oe     (port_c_pad_oe[i]),
            .pad_sync   (c_sync[i])
        );
    end

    // Peripheral input steering; idle rx, sda and scl rest high like a pulled-up pin, the clock line rests low
    always_comb begin
        next_rx        = 1'b1;
        next_sda       = 1'b1;
        next_scl       = 1'b1;
        next_clk       = 1'b0;
        next_clk_valid = 1'b0;
        if (ctl.b6_sel == B6_RX) begin
            next_rx = b_sync[B6];
        end else if (ctl.b7_sel == B7_TX && periph.serial0_single_wire) begin
            next_rx = b_sync[B7];
        end
        if (ctl.b6_sel == B6_SDA && !ctl.i2c_on_b1_b0) begin
            next_sda = b_sync[B6];
        end
        if (ctl.b7_sel == B7_SCL && !ctl.i2c_on_b1_b0) begin
            next_scl = b_sync[B7];
        end
        if (ctl.b6_sel == B6_EXT_CLOCK_IN && ctl.osc_clock_mode_bit) begin
            next_clk       = b_sync[B6];
            next_clk_valid = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            serial0_rx_in    <= 1'b1;
            sda_in           <= 1'b1;
            scl_in           <= 1'b1;
            ext_clock_in     <= 1'b0;
            ext_clock_valid  <= 1'b0;
            gpio_din         <= 8'h00;
            conv_a_chan_en   <= 3'h0;
            conv_b_chan_en   <= 3'h0;
            comparator_a_in3 <= 1'b0;
            comparator_b_in3 <= 1'b0;
            conv_a_ref_high  <= 1'b0;
            conv_b_ref_high  <= 1'b0;
            i2c_alt_route    <= 1'b0;
        end else begin
            serial0_rx_in    <= next_rx;
            sda_in           <= next_sda;
            scl_in           <= next_scl;
            ext_clock_in     <= next_clk;
            ext_clock_valid  <= next_clk_valid;
            gpio_din         <= {c_sync, b_sync};
            conv_a_chan_en   <= ctl.c_analog[C2:C0];
            conv_b_chan_en   <= ctl.c_analog[C6:C4];
            comparator_a_in3 <= ctl.c_analog[C0];
            comparator_b_in3 <= ctl.c_analog[C4];
            conv_a_ref_high  <= ctl.c_ref_high[0];
            conv_b_ref_high  <= ctl.c_ref_high[1];
            i2c_alt_route    <= ctl.i2c_on_b1_b0;
        end
    end

endmodule : port_b_c_pin_function_mux

// File: bench/pin_mux_checker_properties.sv
// Port-level assertions for the port B/C pin function mux
`timescale 1ns/1ps
module pin_mux_checker
    import pin_mux_pkg::*;
(
    // Clock and reset
    input wire logic       clk,
    input wire logic       reset_n,
    // Controls and pads
    input wire mux_ctrl_s  ctrl,
    input wire gpio_ctrl_s gpio,
    input wire logic [1:0] port_b_pad_i,
    input wire logic [5:0] port_c_pad_i,
    input wire logic [1:0] port_b_pad_oe,
    input wire logic [5:0] port_c_pad_oe,
    // Observed outputs
    input wire logic [7:0] gpio_din,
    input wire logic       ext_clock_valid,
    input wire logic [2:0] conv_a_chan_en,
    input wire logic [2:0] conv_b_chan_en,
    input wire logic       comparator_a_in3,
    input wire logic       comparator_b_in3,
    input wire logic       conv_a_ref_high,
    input wire logic       conv_b_ref_high
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Edges since reset, so $past never reaches back into a reset
    logic [2:0] up;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            up <= 3'h0;
        end else begin
            up <= {up[1:0], 1'b1};
        end
    end
    property p_gpio_oe;
        up[1] && $past(ctrl, 2) == 14'h0000 |-> {port_c_pad_oe, port_b_pad_oe} == $past(gpio.dir);
    endproperty
    a_gpio_oe: assert property (p_gpio_oe) else $error("gpio oe wrong");
    property p_analog_off;
        up[1] |-> (port_c_pad_oe & $past(ctrl.c_analog, 2)) == 6'h00;
    endproperty
    a_analog_off: assert property (p_analog_off) else $error("analog pin driven");
    property p_rx_off;
        up[1] && $past(ctrl.b6_sel, 2) == B6_RX |-> !port_b_pad_oe[0];
    endproperty
    a_rx_off: assert property (p_rx_off) else $error("rx pin driven");
    property p_conv_a;
        up[1] |-> conv_a_chan_en == $past(ctrl.c_analog[2:0], 2);
    endproperty
    a_conv_a: assert property (p_conv_a) else $error("conv a map");
    property p_conv_b;
        up[1] |-> conv_b_chan_en == $past(ctrl.c_analog[5:3], 2);
    endproperty
    a_conv_b: assert property (p_conv_b) else $error("conv b map");
    property p_cmp;
        comparator_a_in3 == conv_a_chan_en[0] && comparator_b_in3 == conv_b_chan_en[0];
    endproperty
    a_cmp: assert property (p_cmp) else $error("comparator feed");
    property p_ref;
        up[1] |-> {conv_b_ref_high, conv_a_ref_high} == $past(ctrl.c_ref_high, 2);
    endproperty
    a_ref: assert property (p_ref) else $error("ref high");
    property p_clk_off;
        !ctrl.osc_clock_mode_bit [*4] |-> !ext_clock_valid;
    endproperty
    a_clk_off: assert property (p_clk_off) else $error("clock without mode");
    property p_din;
        up[2] |-> gpio_din == $past({port_c_pad_i, port_b_pad_i}, 3);
    endproperty
    a_din: assert property (p_din) else $error("gpio input");
endmodule : pin_mux_checker

bind port_b_c_pin_function_mux pin_mux_checker u_chk (.clk, .reset_n, .ctrl, .gpio,
    .port_b_pad_i, .port_c_pad_i, .port_b_pad_oe, .port_c_pad_oe, .gpio_din, .ext_clock_valid,
    .conv_a_chan_en, .conv_b_chan_en, .comparator_a_in3, .comparator_b_in3, .conv_a_ref_high,
    .conv_b_ref_high);

// File: bench/pin_mux_ext_pins.sv
// Board model of the pads: pull-ups on port B, floating port C
`timescale 1ns/1ps
module pin_mux_ext_pins (
    // Chip drive
    input  wire logic [7:0] pad_o,
    input  wire logic [7:0] pad_oe,
    // Board drive
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    // Resolved level
    output logic      [7:0] pad_i
);
    // No pull on port C, so a released pin must not keep showing its last level
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pad_i[i] = pad_oe[i] ? pad_o[i] : ext_en[i] ? ext_val[i] : (i < 2) | ~pad_o[i];
        end
    end
endmodule : pin_mux_ext_pins

// File: bench/port_b_c_pin_function_mux_tb_top.sv
// Testbench for the port B/C pin function mux
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin fails++; \
    $display("BAD %s exp %h got %h", nm, exp, got); end end
module port_b_c_pin_function_mux_tb_top
    import pin_mux_pkg::*;
;
    logic clk = 0, reset_n = 0, rx, sda, scl, eclk, eclk_ok, cmpa, cmpb, refa, refb, i2c_alt;
    mux_ctrl_s ctrl;
    gpio_ctrl_s gpio;
    periph_drive_s periph;
    logic [7:0] ext_en, ext_val, pad_i, pad_o, pad_oe, gpio_din;
    logic [2:0] ca, cb;
    int fails = 0, samples_checked = 0;
    always #2.5 clk = ~clk;
    port_b_c_pin_function_mux u_dut (.clk(clk), .reset_n(reset_n), .ctrl(ctrl), .gpio(gpio),
        .periph(periph), .port_b_pad_i(pad_i[1:0]), .port_b_pad_o(pad_o[1:0]),
        .port_b_pad_oe(pad_oe[1:0]), .port_c_pad_i(pad_i[7:2]), .port_c_pad_o(pad_o[7:2]),
        .port_c_pad_oe(pad_oe[7:2]), .gpio_din(gpio_din), .serial0_rx_in(rx), .sda_in(sda),
        .scl_in(scl), .ext_clock_in(eclk), .ext_clock_valid(eclk_ok), .conv_a_chan_en(ca),
        .conv_b_chan_en(cb), .comparator_a_in3(cmpa), .comparator_b_in3(cmpb),
        .conv_a_ref_high(refa), .conv_b_ref_high(refb), .i2c_alt_route(i2c_alt));
    pin_mux_ext_pins u_pins (.pad_o(pad_o), .pad_oe(pad_oe), .ext_en(ext_en),
        .ext_val(ext_val), .pad_i(pad_i));
    task wt(input int n);
        repeat (n) @(negedge clk);
    endtask : wt
    task t_reset;
        `CHK("oe", 8'h00, pad_oe)
        `CHK("ana", 10'h000, {ca, cb, cmpa, cmpb, refa, refb})
    endtask : t_reset
    task t_gpio;
        for (int i = 0; i < 8; i++) begin
            gpio = {8'h01 << i, 8'hff};
            wt(2);
            `CHK("dir", gpio.dir, pad_oe)
            `CHK("dout", 1'b1, pad_o[i])
        end
        gpio = 16'h0000;
        ext_en = 8'hff;
        ext_val = 8'ha5;
        wt(4);
        `CHK("din", 8'ha5, gpio_din)
    endtask : t_gpio
    task t_b6;
        gpio = 16'h0101;
        ext_val = 8'h00;
        for (int s = 0; s < 8; s++) begin
            ctrl.b6_sel = s[2:1];
            ctrl.osc_clock_mode_bit = s[0];
            // Releasing the pad takes two edges, then three more reach rx
            wt(5);
            `CHK("b6oe", s < 2 || s == 6, pad_oe[0])
            `CHK("rx", s[2:1] != 2'h1, rx)
            `CHK("sda", s[2:1] != 2'h2, sda)
            `CHK("clk", s == 7, eclk_ok)
        end
        // Clock input still selected: a high pad level must reach the clock line
        ext_val = 8'h01;
        wt(4);
        `CHK("eclk", 1'b1, eclk)
        ctrl = 14'h0000;
    endtask : t_b6
    task t_b7;
        gpio = 16'h0202;
        ctrl.b7_sel = B7_TX;
        periph = 5'h08;
        wt(4);
        `CHK("tx", 2'h2, {pad_oe[1], pad_o[1]})
        periph = 5'h04;
        wt(4);
        `CHK("wire", 2'h0, {pad_oe[1], rx})
        ctrl.b7_sel = B7_SCL;
        periph = 5'h01;
        wt(4);
        `CHK("scl", 2'h2, {pad_oe[1], pad_o[1]})
        periph = 5'h00;
        wt(4);
        `CHK("sclin", 1'b0, scl)
        ctrl.b7_sel = B7_RSVD;
        wt(3);
        `CHK("rsvd", 1'b1, pad_oe[1])
        ctrl = 14'h0000;
    endtask : t_b7
    task t_analog;
        gpio = 16'hffff;
        for (int i = 0; i < 6; i++) begin
            ctrl.c_analog = 6'h01 << i;
            wt(3);
            `CHK("chan", 6'h01 << i, {cb, ca})
            `CHK("cmp", {i == 3, i == 0}, {cmpb, cmpa})
            `CHK("aoe", ~(6'h01 << i), pad_oe[7:2])
        end
        ctrl.c_analog = 6'h00;
        for (int r = 0; r < 2; r++) begin
            ctrl.c_ref_high = 2'h1 << r;
            wt(3);
            `CHK("ref", 2'h1 << r, {refb, refa})
            `CHK("refoe", 7'h00, {pad_oe[r ? 7 : 4], ca, cb})
        end
        // Reset in mid-run with analog and drive set must fall back to plain GPIO
        ctrl.c_analog = 6'h3f;
        wt(3);
        reset_n = 1'b0;
        wt(1);
        t_reset();
        reset_n = 1'b1;
        ctrl = 14'h0000;
    endtask : t_analog
    task t_i2c;
        gpio = 16'h0000;
        ctrl.i2c_on_b1_b0 = 1'b1;
        ctrl.b6_sel = B6_SDA;
        periph = 5'h02;
        wt(3);
        `CHK("alt", 2'h2, {i2c_alt, pad_oe[0]})
    endtask : t_i2c
    task complete_run;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run
    initial begin
        ctrl = 14'h0000;
        gpio = 16'h0000;
        periph = 5'h00;
        ext_en = 8'h00;
        ext_val = 8'h00;
        repeat (4) @(posedge clk);
        @(negedge clk) reset_n = 1'b1;
        t_reset();
        t_gpio();
        t_b6();
        t_b7();
        t_analog();
        t_i2c();
        complete_run();
    end
    // About seventeen times the length of the sequence above
    initial begin
        repeat (2000) @(posedge clk);
        fails++;
        complete_run();
    end
endmodule : port_b_c_pin_function_mux_tb_top
